// [src/psbpwm_top.sv]
/*
 phase-shift full-bridge output logic: two legs, phase shift, dead time, fault blanking,
 soft start and soft stop, axi4-lite register access and an interrupt.
 assumes comparator levels and sync arrive asynchronously and pass two flip-flops here.
*/
// Contract
// - leg one outputs are exact complements apart from dead time
// - each leg output toggles at half oscillator rate, near half duty
// - leg two behaves like leg one: complementary, half rate, half duty
// - leg two outputs lag leg one outputs by the commanded phase shift
// - leg two may leave half duty while phase shift changes
// - both leg outputs low for the dead time before complement turns on
// - each leg has its own dead-time setting
// - per-leg option removes dead time, outputs switch as pure complements
// - full adaptive mode: zero-current dead time is four times peak-current dead time
// - adaptive off applies programmed dead time unchanged
// - no-load below 500 mV blanks outputs until above 600 mV
// - peak-current mode ends active pulse when current reaches threshold
// - overcurrent blanks outputs, soft stop, then full soft start
// - any disable or fault forces all four outputs low at once
// - soft stop lasts until soft-start level below disable threshold
// - external sync drive replaces internal oscillator as clock
`timescale 1ns/10ps
`default_nettype none
module psbpwm_top
   import psbpwm_pkg::*;
#(
   parameter int CW = 16
) (
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   input  wire logic         no_load_in,
   input  wire logic         current_limit_in,
   input  wire logic         overcurrent_in,
   input  wire logic         shutdown_n_in,
   input  wire logic         sync_in,
   output logic              sync_out,
   output logic              sync_oe,
   output logic              leg1_first_drive,
   output logic              leg1_second_drive,
   output logic              leg2_first_drive,
   output logic              leg2_second_drive,
   output logic              irq
);
   if (CW < 4 || CW > 16) begin : g_cw_check
      $error("CW must be 4..16");
   end

   typedef enum logic [3:0] {
      ST_START = 4'b0001,
      ST_RUN   = 4'b0010,
      ST_STOP  = 4'b0100,
      ST_HOLD  = 4'b1000
   } psbpwm_state_t;

   // registers
   logic [31:0]       ctrl_ff;
   logic [15:0]       period_ff, phase_ff, dead1_ff, dead2_ff, ss_time_ff;
   logic [IRQ_W-1:0]  irq_stat_ff, irq_mask_ff;
   // synchronisers: stage one is read only by stage two
   psbpwm_flags_t     s1_ff, s2_ff;
   logic              sync1_ff, sync2_ff, sync3_ff;
   logic              noload_ff;
   psbpwm_state_t     state_ff;
   logic [15:0]       osc_ff, ss_ff, lag_ff;
   logic              cmd1_ff, cmd2_ff, clim_cut_ff;
   logic              aw_ff, w_ff;
   logic [7:0]        awaddr_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s1_ff    <= 4'h1;
         s2_ff    <= 4'h1;
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
      end else begin
         s1_ff    <= {no_load_in, current_limit_in, overcurrent_in, shutdown_n_in};
         s2_ff    <= s1_ff;
         sync1_ff <= sync_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // no-load comparator already carries 500/600 mV hysteresis; hold its level here
   always_ff @(posedge core_clk) begin
      if (!reset_n) noload_ff <= 1'b1;
      else noload_ff <= s2_ff.no_load;
   end

   // oscillator tick: internal divider or external sync rising edge
   logic ext_sync, osc_tick, running, kill;
   assign ext_sync = ctrl_ff[CTRL_SYNC_BIT];
   assign osc_tick = ext_sync ? (sync2_ff && !sync3_ff)
                              : (osc_ff == 16'h0);
   assign running  = (state_ff == ST_RUN) && ctrl_ff[CTRL_EN_BIT];
   // no-load blanks from the synchroniser, as fast as the other faults
   assign kill     = !running || s2_ff.no_load || !s2_ff.disable_n || s2_ff.ovc
                     || clim_cut_ff;

   always_ff @(posedge core_clk) begin
      if (!reset_n) osc_ff <= 16'h0;
      else if (osc_ff == 16'h0) osc_ff <= period_ff - 16'h1;
      else osc_ff <= osc_ff - 16'h1;
   end

   // legs toggle at half oscillator rate; leg two command lags by phase count
   logic lag_zero;
   assign lag_zero = (lag_ff == 16'h0);
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cmd1_ff <= 1'b0;
         cmd2_ff <= 1'b0;
         lag_ff  <= 16'h0;
      end else begin
         if (osc_tick) begin
            cmd1_ff <= !cmd1_ff;
            lag_ff  <= phase_ff;
         end else if (!lag_zero) begin
            lag_ff  <= lag_ff - 16'h1;
         end
         // a new phase value just stretches or trims one leg-two half cycle
         if ((osc_tick && phase_ff == 16'h0) || lag_ff == 16'h1) begin
            cmd2_ff <= osc_tick ? !cmd1_ff : cmd1_ff;
         end
      end
   end

   // peak-current mode: pulse ends for the rest of this cycle
   always_ff @(posedge core_clk) begin
      if (!reset_n) clim_cut_ff <= 1'b0;
      else if (osc_tick) clim_cut_ff <= 1'b0;
      else if (ctrl_ff[CTRL_PEAK_BIT] && s2_ff.clim) clim_cut_ff <= 1'b1;
   end

   // adaptive dead time: at zero current 4x the peak-current value
   logic [15:0] dead1_eff, dead2_eff;
   logic        full_ad, quarter;
   assign full_ad   = (ctrl_ff[CTRL_ADAPT_LSB +: CTRL_ADAPT_W] == ADAPT_FULL);
   assign quarter   = full_ad && s2_ff.clim;
   assign dead1_eff = quarter ? {2'h0, dead1_ff[15:2]} : dead1_ff;
   assign dead2_eff = quarter ? {2'h0, dead2_ff[15:2]} : dead2_ff;

   psbpwm_pair_t d1, d2;
   psbpwm_leg #(.CW(CW)) u_leg1 (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .phase_cmd(cmd1_ff),
      .kill     (kill),
      .no_dead  (ctrl_ff[CTRL_NODEAD1]),
      .dead_cnt (dead1_eff[CW-1:0]),
      .drive    (d1)
   );
   psbpwm_leg #(.CW(CW)) u_leg2 (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .phase_cmd(cmd2_ff),
      .kill     (kill),
      .no_dead  (ctrl_ff[CTRL_NODEAD2]),
      .dead_cnt (dead2_eff[CW-1:0]),
      .drive    (d2)
   );
   // legs already register their drives; repeat kill so blanking lands in one edge
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         leg1_first_drive  <= 1'b0;
         leg1_second_drive <= 1'b0;
         leg2_first_drive  <= 1'b0;
         leg2_second_drive <= 1'b0;
      end else begin
         leg1_first_drive  <= d1.first && !kill;
         leg1_second_drive <= d1.second && !kill;
         leg2_first_drive  <= d2.first && !kill;
         leg2_second_drive <= d2.second && !kill;
      end
   end

   // soft-start level model: ramps up in start, down in stop
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_ff <= ST_START;
         ss_ff    <= 16'h0;
      end else begin
         case (state_ff)
            ST_START: begin
               if (!s2_ff.disable_n) ss_ff <= 16'h0;
               else if (ss_ff >= ss_time_ff) state_ff <= ST_RUN;
               else ss_ff <= ss_ff + 16'h1;
            end
            ST_RUN: begin
               if (s2_ff.ovc) state_ff <= ST_STOP;
               else if (!s2_ff.disable_n) state_ff <= ST_HOLD;
            end
            ST_STOP: begin
               if (ss_ff <= SSTOP_TIME) begin
                  ss_ff    <= 16'h0;
                  state_ff <= ST_START;
               end else begin
                  ss_ff <= ss_ff - SSTOP_TIME;
               end
            end
            ST_HOLD: begin
               ss_ff <= 16'h0;
               if (s2_ff.disable_n) state_ff <= ST_START;
            end
            default: state_ff <= ST_START;
         endcase
      end
   end

   // sync pin drives out the internal clock when not taking an external one
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sync_out <= 1'b0;
         sync_oe  <= 1'b0;
      end else begin
         sync_out <= !ext_sync && osc_tick;
         sync_oe  <= !ext_sync;
      end
   end

   // axi4-lite write: address and data taken in either order
   logic do_write, w_hit;
   logic [IRQ_W-1:0] ev;
   assign do_write = aw_ff && w_ff && !s_axi_bvalid;
   assign ev = {!s2_ff.disable_n, s2_ff.ovc, s2_ff.clim, noload_ff};
   assign w_hit = (awaddr_ff == ADDR_CTRL) || (awaddr_ff == ADDR_PERIOD)
                  || (awaddr_ff == ADDR_PHASE) || (awaddr_ff == ADDR_DEAD1)
                  || (awaddr_ff == ADDR_DEAD2) || (awaddr_ff == ADDR_IRQ_STAT)
                  || (awaddr_ff == ADDR_IRQ_MASK) || (awaddr_ff == ADDR_SS_TIME);

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         aw_ff <= 1'b0;
         w_ff  <= 1'b0;
         awaddr_ff <= 8'h0;
         wdata_ff  <= 32'h0;
         wstrb_ff  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_ff <= 1'b0;
            w_ff  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_ff;
   assign s_axi_wready  = !w_ff;

   logic [31:0] wmask, wval;
   assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   assign wval  = wdata_ff & wmask;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ctrl_ff    <= CTRL_RST;
         period_ff  <= PERIOD_RST;
         phase_ff   <= PHASE_RST;
         dead1_ff   <= DEAD_RST;
         dead2_ff   <= DEAD_RST;
         ss_time_ff <= SS_TIME_RST;
         irq_mask_ff <= '0;
         irq_stat_ff <= '0;
      end else begin
         if (do_write && awaddr_ff == ADDR_CTRL)
            ctrl_ff <= (ctrl_ff & ~wmask) | wval;
         if (do_write && awaddr_ff == ADDR_PERIOD && wval[15:0] > 16'h1)
            period_ff <= wval[15:0];
         if (do_write && awaddr_ff == ADDR_PHASE)
            phase_ff <= wval[15:0];
         if (do_write && awaddr_ff == ADDR_DEAD1)
            dead1_ff <= wval[15:0];
         if (do_write && awaddr_ff == ADDR_DEAD2)
            dead2_ff <= wval[15:0];
         if (do_write && awaddr_ff == ADDR_SS_TIME)
            ss_time_ff <= wval[15:0];
         if (do_write && awaddr_ff == ADDR_IRQ_MASK)
            irq_mask_ff <= wval[IRQ_W-1:0];
         // a new event wins over a write-one clear in the same cycle
         irq_stat_ff <= (irq_stat_ff & ~((do_write && awaddr_ff == ADDR_IRQ_STAT)
                        ? wval[IRQ_W-1:0] : {IRQ_W{1'b0}})) | ev;
      end
   end

   // axi4-lite read
   logic [31:0] rd_mux;
   assign rd_mux = (s_axi_araddr == ADDR_CTRL)     ? ctrl_ff :
                   (s_axi_araddr == ADDR_PERIOD)   ? {16'h0, period_ff} :
                   (s_axi_araddr == ADDR_PHASE)    ? {16'h0, phase_ff} :
                   (s_axi_araddr == ADDR_DEAD1)    ? {16'h0, dead1_ff} :
                   (s_axi_araddr == ADDR_DEAD2)    ? {16'h0, dead2_ff} :
                   (s_axi_araddr == ADDR_STATUS)   ? {24'h0, state_ff, ev} :
                   (s_axi_araddr == ADDR_IRQ_STAT) ? {28'h0, irq_stat_ff} :
                   (s_axi_araddr == ADDR_IRQ_MASK) ? {28'h0, irq_mask_ff} :
                   (s_axi_araddr == ADDR_SS_TIME)  ? {16'h0, ss_time_ff} : 32'h0;
   logic r_hit;
   assign r_hit = (s_axi_araddr <= ADDR_SS_TIME) && (s_axi_araddr[1:0] == 2'h0);
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
         irq          <= 1'b0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= r_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         irq <= |(irq_stat_ff & irq_mask_ff);
      end
   end
   assign s_axi_arready = !s_axi_rvalid;

   // checks
   property p_leg1_comp;
      @(posedge core_clk) disable iff (!reset_n)
         !(leg1_first_drive && leg1_second_drive);
   endproperty
   a_leg1_comp: assert property (p_leg1_comp) else $error("leg1 overlap");
   property p_leg2_comp;
      @(posedge core_clk) disable iff (!reset_n)
         !(leg2_first_drive && leg2_second_drive);
   endproperty
   a_leg2_comp: assert property (p_leg2_comp) else $error("leg2 overlap");
   property p_half_rate;
      @(posedge core_clk) disable iff (!reset_n)
         osc_tick |=> (cmd1_ff != $past(cmd1_ff));
   endproperty
   a_half_rate: assert property (p_half_rate) else $error("leg1 did not toggle");
   property p_fault_kill;
      @(posedge core_clk) disable iff (!reset_n)
         (s2_ff.ovc || !s2_ff.disable_n) |=> ##1 !(leg1_first_drive || leg1_second_drive
            || leg2_first_drive || leg2_second_drive);
   endproperty
   a_fault_kill: assert property (p_fault_kill) else $error("outputs not blanked");
   property p_ovc_stop;
      @(posedge core_clk) disable iff (!reset_n)
         (state_ff == ST_RUN && s2_ff.ovc) |=> state_ff == ST_STOP;
   endproperty
   a_ovc_stop: assert property (p_ovc_stop) else $error("no soft stop");
   property p_stop_to_start;
      @(posedge core_clk) disable iff (!reset_n)
         (state_ff == ST_STOP && ss_ff <= SSTOP_TIME) |=> state_ff == ST_START && ss_ff == 16'h0;
   endproperty
   a_stop_to_start: assert property (p_stop_to_start) else $error("soft stop end");
   property p_noload;
      @(posedge core_clk) disable iff (!reset_n)
         s2_ff.no_load |=> ##1 !(leg1_first_drive || leg2_first_drive);
   endproperty
   a_noload: assert property (p_noload) else $error("no-load not blanked");
   property p_start_quiet;
      @(posedge core_clk) disable iff (!reset_n)
         (state_ff == ST_START) |=> ##1 !(leg1_first_drive || leg1_second_drive);
   endproperty
   a_start_quiet: assert property (p_start_quiet) else $error("switching in soft start");
endmodule
`default_nettype wire

// [src/psbpwm_pkg.sv]
/*
 package for the phase-shift bridge pwm block: register map, field positions, reset values,
 timing counts and carrier types.
 assumes a 100 mhz core clock and an axi4-lite register bus.
*/
package psbpwm_pkg;
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_PERIOD   = 8'h04;
   localparam logic [7:0]  ADDR_PHASE    = 8'h08;
   localparam logic [7:0]  ADDR_DEAD1    = 8'h0c;
   localparam logic [7:0]  ADDR_DEAD2    = 8'h10;
   localparam logic [7:0]  ADDR_STATUS   = 8'h14;
   localparam logic [7:0]  ADDR_IRQ_STAT = 8'h18;
   localparam logic [7:0]  ADDR_IRQ_MASK = 8'h1c;
   localparam logic [7:0]  ADDR_SS_TIME  = 8'h20;
   // ctrl fields
   localparam int CTRL_EN_BIT     = 0;
   localparam int CTRL_PEAK_BIT   = 1;
   localparam int CTRL_NODEAD1    = 2;
   localparam int CTRL_NODEAD2    = 3;
   localparam int CTRL_ADAPT_LSB  = 4;
   localparam int CTRL_ADAPT_W    = 2;
   localparam int CTRL_SYNC_BIT   = 6;
   // adaptive selections: full scales by load, off keeps dead time fixed
   localparam logic [1:0] ADAPT_OFF  = 2'h0;
   localparam logic [1:0] ADAPT_FULL = 2'h1;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
   localparam logic [15:0] PERIOD_RST   = 16'h0064;
   localparam logic [15:0] PHASE_RST    = 16'h0000;
   localparam logic [15:0] DEAD_RST     = 16'h0008;
   localparam int          SS_TIME_US   = 100;
   localparam int          CLK_MHZ      = 100;
   localparam logic [15:0] SS_TIME_RST  = 16'(SS_TIME_US * CLK_MHZ / 10);
   localparam logic [15:0] SSTOP_TIME   = 16'h0010;
   // irq bits
   localparam int IRQ_NOLOAD = 0;
   localparam int IRQ_CLIM   = 1;
   localparam int IRQ_OVC    = 2;
   localparam int IRQ_DIS    = 3;
   localparam int IRQ_W      = 4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic no_load;
      logic clim;
      logic ovc;
      logic disable_n;
   } psbpwm_flags_t;

   typedef struct packed {
      logic first;
      logic second;
   } psbpwm_pair_t;
endpackage

// [src/psbpwm_leg.sv]
/*
 one bridge leg: takes a square phase command and makes a complementary output pair with
 dead time inserted on each turn-on.
 assumes the command and dead count are on core_clk; kill forces outputs low at once.
*/
`timescale 1ns/10ps
`default_nettype none
module psbpwm_leg
   import psbpwm_pkg::*;
#(
   parameter int CW = 16
) (
   input  wire logic          core_clk,
   input  wire logic          reset_n,
   input  wire logic          phase_cmd,
   input  wire logic          kill,
   input  wire logic          no_dead,
   input  wire logic [CW-1:0] dead_cnt,
   output var  psbpwm_pair_t  drive
);
   logic          cmd_ff;
   logic [CW-1:0] gap_ff;
   logic          gap_zero;
   psbpwm_pair_t  nxt_drive;

   assign gap_zero = (gap_ff == '0);
   // both low while the gap runs; pure complements when dead time is off
   assign nxt_drive.first  = !kill && cmd_ff && (no_dead || gap_zero);
   assign nxt_drive.second = !kill && !cmd_ff && (no_dead || gap_zero);

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cmd_ff <= 1'b0;
         gap_ff <= '0;
         drive  <= '0;
      end else begin
         cmd_ff <= phase_cmd;
         if (phase_cmd != cmd_ff) begin
            gap_ff <= dead_cnt;
         end else if (!gap_zero) begin
            gap_ff <= gap_ff - CW'(1);
         end
         drive <= nxt_drive;
      end
   end

   property p_dead_gap;
      @(posedge core_clk) disable iff (!reset_n)
         !(drive.first && drive.second);
   endproperty
   a_dead_gap: assert property (p_dead_gap) else $error("leg outputs overlap");
endmodule
`default_nettype wire

// [dv/psbpwm_gate_model.sv]
/*
 gate driver model for both bridge legs: counts cycles with both switches of one leg on.
 assumes the drive levels are registered on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module psbpwm_gate_model
   import psbpwm_pkg::*;
(
   input  wire logic         core_clk,
   input  wire psbpwm_pair_t leg1,
   input  wire psbpwm_pair_t leg2,
   output var  int           shoot_cnt
);
   initial shoot_cnt = 0;
   // a real leg shorts the rail here, so any count is a lost bridge
   always @(posedge core_clk) begin
      if ((leg1.first && leg1.second) || (leg2.first && leg2.second)) begin
         shoot_cnt <= shoot_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// [dv/psbpwm_top_tb.sv]
/*
 bench for the phase-shift bridge pwm: axi4-lite master, gate model, timing and fault checks.
 assumes a 100 mhz clock; sync pin shared with an outside source ticking every 30 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module psbpwm_top_tb
   import psbpwm_pkg::*;
;
   localparam int PER = 20;
   logic core_clk, reset_n, ext_sync, irq, sync_out, sync_oe;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, d1, d2, ph;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic no_load_in, current_limit_in, overcurrent_in, shutdown_n_in;
   logic leg1_first_drive, leg1_second_drive, leg2_first_drive, leg2_second_drive;
   wire logic sync_in;
   int miscompares, compares, shoot_cnt, n;
   logic [33:0] exp_q[$];
   logic [7:0] ra[6];
   logic [31:0] rv[6];
   // shared pin: the device owns it while its enable is high
   assign sync_in = sync_oe ? sync_out : ext_sync;
   psbpwm_top #(.CW(16)) i_dut (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .no_load_in,
      .current_limit_in, .overcurrent_in, .shutdown_n_in, .sync_in, .sync_out, .sync_oe,
      .leg1_first_drive, .leg1_second_drive, .leg2_first_drive, .leg2_second_drive, .irq);
   psbpwm_gate_model i_gate (.core_clk, .leg1({leg1_first_drive, leg1_second_drive}),
      .leg2({leg2_first_drive, leg2_second_drive}), .shoot_cnt);
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      ext_sync = 0;
      forever begin
         repeat (15) @(posedge core_clk);
         ext_sync <= ~ext_sync;
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // responses are matched in issue order, one transfer in flight at a time
   always @(posedge core_clk) begin
      if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_ok, w_ok;
      @(posedge core_clk);
      exp_q.push_back({r, 32'h0});
      {aw_ok, w_ok} = 2'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!(aw_ok && w_ok)) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) aw_ok = 1'b1;
         if (s_axi_wvalid && s_axi_wready) w_ok = 1'b1;
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
      end
      do @(posedge core_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge core_clk);
      exp_q.push_back({r, d});
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   function automatic logic fst(input int k);
      return k ? leg2_first_drive : leg1_first_drive;
   endfunction
   task automatic fall_of(input int k);
      do @(negedge core_clk); while (!fst(k));
      do @(negedge core_clk); while (fst(k));
   endtask
   task automatic gap(input int k, input int e);
      // the first fall may still carry the setting from before the last write
      repeat (2) fall_of(k);
      n = 0;
      while (!(k ? leg2_second_drive : leg1_second_drive)) begin
         n++;
         @(negedge core_clk);
      end
      chk(34'(n), 34'(e));
   endtask
   task automatic period(input int e);
      repeat (2) fall_of(0);
      n = 0;
      while (!fst(0)) begin @(negedge core_clk); n++; end
      while (fst(0)) begin @(negedge core_clk); n++; end
      chk(34'(n), 34'(e));
   endtask
   task automatic give_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // many times the expected run, which is mostly waits for leg edges
   initial begin
      #900000;
      miscompares++;
      give_verdict();
   end
   initial begin
      seed = 32'hd8fd6edf;
      {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {no_load_in, current_limit_in, overcurrent_in, shutdown_n_in} = 4'h1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      ra = '{ADDR_CTRL, ADDR_PERIOD, ADDR_PHASE, ADDR_DEAD1, ADDR_DEAD2, ADDR_SS_TIME};
      rv = '{CTRL_RST, 32'(PERIOD_RST), 32'(PHASE_RST), 32'(DEAD_RST), 32'(DEAD_RST),
         32'(SS_TIME_RST)};
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(negedge core_clk);
      chk(34'({leg1_first_drive, leg1_second_drive, leg2_first_drive, leg2_second_drive}),
         34'h0);
      for (int i = 0; i < 6; i++) rd(ra[i], rv[i], RESP_OKAY);
      rd(8'h24, 32'h0, RESP_SLVERR);
      wr(8'h24, 32'h1, RESP_SLVERR);
      rd(8'h06, 32'h0, RESP_SLVERR);
      $display("test registers done");
      d1 = 32'h1 + rnd() % 32'h6;
      d2 = 32'h1 + rnd() % 32'h6;
      ph = 32'h1 + rnd() % 32'hc;
      wr(ADDR_SS_TIME, 32'h4, RESP_OKAY);
      wr(ADDR_PERIOD, 32'(PER), RESP_OKAY);
      wr(ADDR_DEAD1, d1, RESP_OKAY);
      wr(ADDR_DEAD2, d2, RESP_OKAY);
      wr(ADDR_PHASE, ph, RESP_OKAY);
      fall_of(0); // first cycle after a phase change may be stretched
      gap(0, d1);
      gap(1, d2);
      period(2 * PER);
      fall_of(0);
      n = 0;
      while (fst(1)) begin @(negedge core_clk); n++; end
      chk(34'(n), 34'(ph));
      $display("test timing done");
      wr(ADDR_CTRL, 32'hd, RESP_OKAY);
      gap(0, 0);
      gap(1, 0);
      wr(ADDR_DEAD1, 32'h8, RESP_OKAY);
      current_limit_in <= 1'b1;
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      gap(0, 8);
      wr(ADDR_CTRL, 32'h11, RESP_OKAY);
      gap(0, 2);
      wr(ADDR_CTRL, 32'h3, RESP_OKAY);
      repeat (2) @(negedge core_clk);
      n = 0;
      repeat (50) begin
         @(negedge core_clk);
         n += 32'(leg1_first_drive | leg1_second_drive | leg2_first_drive | leg2_second_drive);
      end
      chk(34'(n), 34'h0);
      current_limit_in <= 1'b0;
      wr(ADDR_CTRL, 32'h41, RESP_OKAY);
      period(60);
      chk(34'({sync_oe, sync_out}), 34'h0);
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      $display("test dead time and sync done");
      wr(ADDR_IRQ_STAT, 32'hf, RESP_OKAY);
      chk(34'(sync_oe), 34'h1);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_IRQ_MASK, i ? 32'hf : 32'h0, RESP_OKAY);
         do @(negedge core_clk); while (!leg1_first_drive);
         @(posedge core_clk);
         {no_load_in, overcurrent_in, shutdown_n_in} <= {i == 0, i == 1, i != 2};
         n = 0;
         do begin @(negedge core_clk); n++; end while (leg1_first_drive | leg1_second_drive
            | leg2_first_drive | leg2_second_drive);
         chk(34'(n <= 4), 34'h1);
         n = 0;
         repeat (8) begin
            @(negedge core_clk);
            n += 32'(leg1_first_drive | leg1_second_drive | leg2_first_drive | leg2_second_drive);
         end
         chk(34'(n), 34'h0);
         chk(34'(irq), 34'(i != 0));
         rd(ADDR_IRQ_STAT, 32'h1 << (i == 0 ? IRQ_NOLOAD : i == 1 ? IRQ_OVC : IRQ_DIS), RESP_OKAY);
         {no_load_in, overcurrent_in, shutdown_n_in} <= 3'h1;
         repeat (4) @(posedge core_clk);
         wr(ADDR_IRQ_STAT, 32'hf, RESP_OKAY);
         rd(ADDR_IRQ_STAT, 32'h0, RESP_OKAY);
         chk(34'(irq), 34'h0);
         fall_of(0); // switching returns; overcurrent first needs soft stop and soft start, disable needs soft start
      end
      $display("test faults done");
      chk(34'(shoot_cnt), 34'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
